// >>> src/sls_pkg.sv
`default_nettype none
package sls_pkg;
  // Register map, printed byte offsets
  localparam logic [11:0] ADDR_STATUS   = 12'h208;
  localparam logic [11:0] ADDR_PWRDN    = 12'h209;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h210;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h211;

  // Status field positions
  localparam int BIT_LINK_UP  = 6;
  localparam int BIT_SYNC     = 5;
  localparam int BIT_REALIGN  = 4;
  localparam int BIT_MF_SET   = 3;
  localparam int BIT_PLL_LOCK = 2;

  // Power-down field positions
  localparam int BIT_SECOND_OFF = 1;
  localparam int BIT_FIRST_OFF  = 0;

  // Interrupt status / mask layout
  localparam int IRQ_REALIGN   = 0;
  localparam int IRQ_MF_SET    = 1;
  localparam int IRQ_LINK_LOST = 2;
  localparam int IRQ_W         = 3;

  // Reset values
  localparam logic [7:0]       PWRDN_RST    = 8'h00;
  localparam logic [1:0]       FLAGS_RST    = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // Status byte as seen by software
  typedef struct packed {
    logic rsvd_hi;
    logic link_up;
    logic sync_level;
    logic realigned;
    logic mf_phase_set;
    logic pll_locked;
    logic [1:0] rsvd_lo;
  } sls_status_t;

  // One register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } sls_bus_req_t;
endpackage : sls_pkg
`default_nettype wire

// >>> src/sls_regs.sv
`default_nettype none
// Functional notes
// - Status has no defined reset value (the code resets it to 8'h20); reserved bits are read-only.
// - Status bit 5 is the live sync request level, 0 while asserted.
// - Status bit 4 sets on a SYSREF realignment and holds until written 1.
// - Bit 3 sets on the first SYSREF after link enable; writing 1 clears it.
// - Status bit 2 reads high while the serial-link PLL is locked.
// - Power-down resets to zero; two read-write bits, rest reserved.
// - Bit 1 powers off channel B, bit 0 channel A, both the subsystem.
module sls_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wr_data,
  input  wire logic              i_wr_stb,
  input  wire logic              i_rd_stb,
  output logic      [7:0]        o_rd_data,
  input  wire logic              i_sync_req_n,
  input  wire logic              i_pll_locked,
  input  wire logic              i_link_up,
  input  wire logic              i_serial_link_enable,
  input  wire logic              i_sysref_evt,
  input  wire logic              i_realign_evt,
  output logic                   o_first_channel_off,
  output logic                   o_second_channel_off,
  output logic                   o_subsystem_off,
  output logic                   o_irq
);

  // Refuse address widths that cannot reach the map
  if (ADDR_W < 10 || ADDR_W > 12) begin : g_chk
    $error("sls_regs: ADDR_W must be 10 to 12");
  end

  sls_pkg::sls_bus_req_t req;
  sls_pkg::sls_status_t  status;

  logic [1:0]              sync_sh_q;
  logic [1:0]              pll_sh_q;
  logic [2:0]              link_sh_q;
  logic                    realign_q;
  logic                    mf_set_q;
  logic                    realign_d;
  logic                    mf_set_d;
  logic                    en_prev_q;
  logic                    armed_q;
  logic                    mf_evt;
  logic [1:0]              pwrdn_q;
  logic [1:0]              pwrdn_d;
  logic                    sub_off_q;
  logic [sls_pkg::IRQ_W-1:0] irq_stat_q;
  logic [sls_pkg::IRQ_W-1:0] irq_stat_d;
  logic [sls_pkg::IRQ_W-1:0] irq_mask_q;
  logic [sls_pkg::IRQ_W-1:0] irq_mask_d;
  logic [sls_pkg::IRQ_W-1:0] irq_evt;
  logic                    irq_q;
  logic [7:0]              rd_data_q;
  logic                    wr_status;
  logic                    rd_irq;

  // Bus request bundle, address zero-extended to the map width
  always_comb begin
    req.wr    = i_wr_stb;
    req.rd    = i_rd_stb;
    req.addr  = 12'(i_addr);
    req.wdata = i_wr_data;
  end

  assign wr_status = req.wr && (req.addr == sls_pkg::ADDR_STATUS);
  assign rd_irq    = req.rd && (req.addr == sls_pkg::ADDR_IRQ_STAT);

  // Pin levels: two flops before use, third only for edge finding
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_sh_q <= 2'h3; // Released, the pin's idle level
      pll_sh_q  <= 2'h0;
      link_sh_q <= 3'h0;
    end else begin
      sync_sh_q <= {sync_sh_q[0], i_sync_req_n};
      pll_sh_q  <= {pll_sh_q[0], i_pll_locked};
      link_sh_q <= {link_sh_q[1:0], i_link_up};
    end
  end

  // Arm on encoder enable; only the first SYSREF after it counts
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_prev_q <= 1'b0;
      armed_q   <= 1'b0;
    end else begin
      en_prev_q <= i_serial_link_enable;
      if (!i_serial_link_enable) begin
        armed_q <= 1'b0;
      end else if (!en_prev_q) begin
        armed_q <= 1'b1;
      end else if (i_sysref_evt) begin
        armed_q <= 1'b0;
      end
    end
  end

  assign mf_evt = armed_q && i_serial_link_enable && i_sysref_evt;

  // Sticky alignment flags; a new event beats a same-cycle clear
  always_comb begin
    realign_d = realign_q;
    mf_set_d  = mf_set_q;
    if (wr_status && req.wdata[sls_pkg::BIT_REALIGN]) begin
      realign_d = 1'b0;
    end
    if (wr_status && req.wdata[sls_pkg::BIT_MF_SET]) begin
      mf_set_d = 1'b0;
    end
    if (i_realign_evt) begin
      realign_d = 1'b1;
    end
    if (mf_evt) begin
      mf_set_d = 1'b1;
    end
  end

  // Flags settle to a known value, hardware leaves them undefined
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {realign_q, mf_set_q} <= sls_pkg::FLAGS_RST;
    end else begin
      realign_q <= realign_d;
      mf_set_q  <= mf_set_d;
    end
  end

  // Power-down bits; writes are not blocked while the link runs
  always_comb begin
    pwrdn_d = pwrdn_q;
    if (req.wr && req.addr == sls_pkg::ADDR_PWRDN) begin
      pwrdn_d[sls_pkg::BIT_SECOND_OFF] =
        req.wdata[sls_pkg::BIT_SECOND_OFF];
      pwrdn_d[sls_pkg::BIT_FIRST_OFF]  =
        req.wdata[sls_pkg::BIT_FIRST_OFF];
    end
  end

  // Subsystem-off from the same next value keeps all three power-down outputs in step
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwrdn_q   <= sls_pkg::PWRDN_RST[1:0];
      sub_off_q <= 1'b0;
    end else begin
      pwrdn_q   <= pwrdn_d;
      sub_off_q <= &pwrdn_d;
    end
  end

  // Interrupt events
  always_comb begin
    irq_evt = '0;
    irq_evt[sls_pkg::IRQ_REALIGN]   = i_realign_evt;
    irq_evt[sls_pkg::IRQ_MF_SET]    = mf_evt;
    irq_evt[sls_pkg::IRQ_LINK_LOST] = link_sh_q[2] && !link_sh_q[1];
  end

  // Read clears status, but an event in that cycle survives
  always_comb begin
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (rd_irq) begin
      irq_stat_d = '0;
    end
    irq_stat_d = irq_stat_d | irq_evt;
    if (req.wr && req.addr == sls_pkg::ADDR_IRQ_MASK) begin
      irq_mask_d = req.wdata[sls_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_q <= '0;
      irq_mask_q <= sls_pkg::IRQ_MASK_RST;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= |(irq_stat_d & irq_mask_d);
    end
  end

  // Status byte assembly
  always_comb begin
    status              = '0;
    status.link_up      = link_sh_q[1];
    status.sync_level   = sync_sh_q[1];
    status.realigned    = realign_q;
    status.mf_phase_set = mf_set_q;
    status.pll_locked   = pll_sh_q[1];
  end

  // Read data valid only the cycle after the strobe; unmapped reads 0
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_data_q <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        sls_pkg::ADDR_STATUS:   rd_data_q <= status;
        sls_pkg::ADDR_PWRDN:    rd_data_q <= {6'h00, pwrdn_q};
        sls_pkg::ADDR_IRQ_STAT: rd_data_q <= {5'h00, irq_stat_q};
        sls_pkg::ADDR_IRQ_MASK: rd_data_q <= {5'h00, irq_mask_q};
        default:                rd_data_q <= 8'h00;
      endcase
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  assign o_rd_data            = rd_data_q;
  assign o_first_channel_off  = pwrdn_q[sls_pkg::BIT_FIRST_OFF];
  assign o_second_channel_off = pwrdn_q[sls_pkg::BIT_SECOND_OFF];
  assign o_subsystem_off      = sub_off_q;
  assign o_irq                = irq_q;

  // Checks
  logic rd_status;
  assign rd_status = req.rd && (req.addr == sls_pkg::ADDR_STATUS);

  // Checker's own record of a counted SYSREF since enable rose; a pulse
  // in the rise cycle itself is not counted
  logic chk_sysref_seen_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chk_sysref_seen_q <= 1'b0;
    end else if (!i_serial_link_enable) begin
      chk_sysref_seen_q <= 1'b0;
    end else if (en_prev_q && i_sysref_evt) begin
      chk_sysref_seen_q <= 1'b1;
    end
  end

  sequence s_enable_rise;
    i_serial_link_enable && !en_prev_q;
  endsequence

  sequence s_first_sysref;
    i_serial_link_enable && en_prev_q && i_sysref_evt && !chk_sysref_seen_q;
  endsequence

  sequence s_rise_with_sysref;
    s_enable_rise ##0 (i_sysref_evt && !mf_set_q);
  endsequence

  sync_level_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    rd_status |=> o_rd_data[sls_pkg::BIT_SYNC] == $past(sync_sh_q[1]))
    else $error("sync level misreported");

  pll_level_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    rd_status |=> o_rd_data[sls_pkg::BIT_PLL_LOCK] == $past(pll_sh_q[1]))
    else $error("pll lock misreported");

  link_level_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    rd_status |=> o_rd_data[sls_pkg::BIT_LINK_UP] == $past(link_sh_q[1]))
    else $error("link up misreported");

  reserved_zero_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    rd_status |=> o_rd_data[7] == 1'b0 && o_rd_data[1:0] == 2'h0)
    else $error("reserved status bits not zero");

  realign_sticky_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    i_realign_evt ##1 (!(wr_status && req.wdata[sls_pkg::BIT_REALIGN]))[*3]
    |-> realign_q)
    else $error("realign flag lost");

  realign_clear_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    wr_status && req.wdata[sls_pkg::BIT_REALIGN] && !i_realign_evt
    |=> !realign_q)
    else $error("realign flag not cleared");

  mf_first_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    s_first_sysref |=> mf_set_q && irq_stat_q[sls_pkg::IRQ_MF_SET])
    else $error("first sysref did not set phase flag");

  mf_rise_skip_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    s_rise_with_sysref |=> !mf_set_q)
    else $error("sysref in the enable cycle set the phase flag");

  mf_ignore_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    i_sysref_evt && !mf_set_q &&
    (chk_sysref_seen_q || !i_serial_link_enable) |=> !mf_set_q)
    else $error("later sysref set the phase flag");

  mf_clear_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    wr_status && req.wdata[sls_pkg::BIT_MF_SET] && !mf_evt |=> !mf_set_q)
    else $error("phase flag not cleared");

  pwrdn_write_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    req.wr && req.addr == sls_pkg::ADDR_PWRDN
    |=> {o_second_channel_off, o_first_channel_off} == $past(req.wdata[1:0]))
    else $error("power-down write not stored");

  subsys_off_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    o_subsystem_off == (o_first_channel_off && o_second_channel_off))
    else $error("subsystem off mismatch");

  irq_level_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    o_irq == |(irq_stat_q & irq_mask_q))
    else $error("interrupt level mismatch");

  // Read port, power-down hold and interrupt read-clear checks
  pwrdn_rsvd_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    req.rd && req.addr == sls_pkg::ADDR_PWRDN |=> o_rd_data[7:2] == 6'h00)
    else $error("reserved power-down bits not zero");

  pwrdn_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !(req.wr && req.addr == sls_pkg::ADDR_PWRDN)
    |=> $stable({o_second_channel_off, o_first_channel_off}))
    else $error("power-down bits changed without a write");

  rd_idle_zero_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !req.rd |=> o_rd_data == 8'h00)
    else $error("read data outside its slot");

  irq_clear_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    rd_irq && irq_evt == '0 |=> irq_stat_q == '0)
    else $error("interrupt status not cleared by read");

endmodule : sls_regs
`default_nettype wire

// >>> testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0, rd = 1'b0;
  logic        sync_n = 1'b1, pll = 1'b0, link = 1'b0;
  logic        en = 1'b0, sysref = 1'b0, realign = 1'b0;
  logic [7:0]  rdata;
  logic        off_a, off_b, off_all, irq;
  int          fails = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [7:0]  v;

  sls_regs #(.ADDR_W(12)) u_dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(rdata),
    .i_sync_req_n(sync_n), .i_pll_locked(pll), .i_link_up(link),
    .i_serial_link_enable(en), .i_sysref_evt(sysref),
    .i_realign_evt(realign), .o_first_channel_off(off_a),
    .o_second_channel_off(off_b), .o_subsystem_off(off_all), .o_irq(irq)
  );

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  // Hang guard, well above the under 200 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One-cycle write strobe
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Data is taken at the edge that closes its one valid cycle
  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  // One-cycle event pulse: 0 for realign, 1 for sysref
  task automatic pulse(input logic use_sysref);
    @(posedge clk);
    if (use_sysref) begin
      sysref <= 1'b1;
    end else begin
      realign <= 1'b1;
    end
    @(posedge clk);
    sysref <= 1'b0;
    realign <= 1'b0;
  endtask : pulse

  task automatic t_reset_vals();
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("status reset", v, 8'h20);
    rd_reg(sls_pkg::ADDR_PWRDN, v);
    check("pwrdn reset", v, 8'h00);
    rd_reg(12'h300, v);
    check("unmapped", v, 8'h00);
  endtask : t_reset_vals

  task automatic t_live_bits();
    pll <= 1'b1;
    link <= 1'b1;
    sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("sync asserted", v, 8'h44);
    sync_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("all live", v, 8'h64);
    // Read-only and reserved bits must shrug off a full write
    wr_reg(sls_pkg::ADDR_STATUS, 8'hff);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("ro bits", v, 8'h64);
  endtask : t_live_bits

  task automatic t_realign_irq();
    wr_reg(sls_pkg::ADDR_IRQ_MASK, 8'h01);
    pulse(1'b0);
    repeat (2) @(posedge clk);
    check("irq on", {7'h0, irq}, 8'h01);
    rd_reg(sls_pkg::ADDR_IRQ_STAT, v);
    check("irq stat", v, 8'h01);
    @(posedge clk);
    check("irq cleared", {7'h0, irq}, 8'h00);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("realign sticky", v, 8'h74);
    wr_reg(sls_pkg::ADDR_STATUS, 8'h10);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("realign w1c", v, 8'h64);
    // Masked event: sticky bit set, no interrupt
    wr_reg(sls_pkg::ADDR_IRQ_MASK, 8'h04);
    pulse(1'b0);
    repeat (2) @(posedge clk);
    check("irq masked", {7'h0, irq}, 8'h00);
    rd_reg(sls_pkg::ADDR_IRQ_STAT, v);
    check("masked stat", v, 8'h01);
    wr_reg(sls_pkg::ADDR_STATUS, 8'h10);
    link <= 1'b0;
    repeat (6) @(posedge clk);
    check("link lost irq", {7'h0, irq}, 8'h01);
    rd_reg(sls_pkg::ADDR_IRQ_STAT, v);
    check("link lost stat", v, 8'h04);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("link down", v, 8'h24);
    link <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : t_realign_irq

  task automatic t_mf_phase();
    pulse(1'b1);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("mf no enable", v, 8'h64);
    // Enable and SYSREF in one cycle: that pulse must not count
    @(posedge clk);
    en <= 1'b1;
    sysref <= 1'b1;
    @(posedge clk);
    sysref <= 1'b0;
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("mf at rise", v, 8'h64);
    pulse(1'b1);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("mf set", v, 8'h6c);
    wr_reg(sls_pkg::ADDR_STATUS, 8'h08);
    pulse(1'b1);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("mf first only", v, 8'h64);
    @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
  endtask : t_mf_phase

  task automatic t_power_down();
    logic [7:0] pats [3];
    pats = '{8'hff, 8'h01, 8'h02};
    foreach (pats[i]) begin
      wr_reg(sls_pkg::ADDR_PWRDN, pats[i]);
      rd_reg(sls_pkg::ADDR_PWRDN, v);
      check("pwrdn rw", v, pats[i] & 8'h03);
      check("chan a off", {7'h0, off_a}, {7'h0, pats[i][0]});
      check("chan b off", {7'h0, off_b}, {7'h0, pats[i][1]});
      check("subsys off", {7'h0, off_all},
            {7'h0, pats[i][0] & pats[i][1]});
    end
  endtask : t_power_down

  // Reset in mid-run must drop stored power-down, mask and flag state
  task automatic t_mid_reset();
    wr_reg(sls_pkg::ADDR_PWRDN, 8'h03);
    wr_reg(sls_pkg::ADDR_IRQ_MASK, 8'h07);
    pulse(1'b0);
    @(posedge clk);
    check("irq before reset", {7'h0, irq}, 8'h01);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check("pins reset", {5'h00, off_all, off_b, off_a}, 8'h00);
    check("irq after reset", {7'h0, irq}, 8'h00);
    rd_reg(sls_pkg::ADDR_PWRDN, v);
    check("pwrdn re-reset", v, 8'h00);
    rd_reg(sls_pkg::ADDR_IRQ_MASK, v);
    check("mask re-reset", v, 8'h00);
    rd_reg(sls_pkg::ADDR_STATUS, v);
    check("flags re-reset", v, 8'h64);
  endtask : t_mid_reset

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset_vals();
    t_live_bits();
    t_realign_irq();
    t_mf_phase();
    t_power_down();
    t_mid_reset();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
